// File: rtl/gbdlc_map.svh
`ifndef GBDLC_MAP_SVH
`define GBDLC_MAP_SVH
`define GBDLC_CODE_W 10
`define GBDLC_CODE_RST 10'h000
`define GBDLC_NUM_CHAN 24
`define GBDLC_IMG_BYTES 48
`define GBDLC_SLV_BASE 6'h3A
`define GBDLC_GC_ADDR 7'h00
`define GBDLC_GC_RESET 8'h06
`define GBDLC_EE_DEV 4'hA
`define GBDLC_EE_WORD0 8'h00
`define GBDLC_CLK_NS 50
`define GBDLC_EE_QTR_NS 2500
`define GBDLC_EE_QTR_CYC ((`GBDLC_EE_QTR_NS + `GBDLC_CLK_NS - 1) / `GBDLC_CLK_NS)
`endif

// File: rtl/gbdlc_pkg.sv
package gbdlc_pkg;
   typedef enum logic [5:0] {
      S_IDLE = 6'h01, S_ADDR = 6'h02, S_ACK = 6'h04,
      S_WDATA = 6'h08, S_RDATA = 6'h10, S_RACK = 6'h20
   } gbdlc_slv_e;
   typedef enum logic [3:0] {
      E_IDLE = 4'h1, E_START = 4'h2, E_BIT = 4'h4, E_STOP = 4'h8
   } gbdlc_ee_e;
   typedef struct packed {
      logic vld;
      logic [5:0] idx;
      logic [7:0] data;
   } gbdlc_byte_s;
   typedef struct packed {
      logic scl_o;
      logic scl_oe_n;
      logic sda_o;
      logic sda_oe_n;
   } gbdlc_od_s;
endpackage : gbdlc_pkg

// File: rtl/gbdlc_ee_rd.sv
`timescale 1ns/1ps
`include "gbdlc_map.svh"
module gbdlc_ee_rd #(
   parameter int unsigned QTR_CYC = `GBDLC_EE_QTR_CYC,
   parameter int unsigned IMG = `GBDLC_IMG_BYTES
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic start,
   input wire logic [1:0] ea,
   input wire logic ee_sda_i,
   output gbdlc_pkg::gbdlc_od_s pins,
   output gbdlc_pkg::gbdlc_byte_s rd_byte,
   output logic busy
);
   import gbdlc_pkg::*;
   localparam logic [6:0] STOP_STEP = 7'(5 + IMG);
   gbdlc_ee_e st_q, st_d;
   logic [15:0] div_q, div_d;
   logic [1:0] qtr_q, qtr_d;
   logic [6:0] step_q, step_d, nstep;
   logic [8:0] tx_q, tx_d, rx_q, rx_d;
   logic [3:0] bit_q, bit_d;
   logic scl_lo_q, scl_lo_d, sda_lo_q, sda_lo_d, busy_q, busy_d, tick, adv;
   gbdlc_byte_s byte_q, byte_d;
   logic [6:0] dev;

   always_comb begin
      dev = {`GBDLC_EE_DEV, 1'b0, ea};
      st_d = st_q;
      qtr_d = qtr_q;
      step_d = step_q;
      tx_d = tx_q;
      rx_d = rx_q;
      bit_d = bit_q;
      scl_lo_d = scl_lo_q;
      sda_lo_d = sda_lo_q;
      busy_d = busy_q;
      byte_d = '0;
      adv = 1'b0;
      nstep = step_q + 7'd1;
      tick = (div_q == 16'(QTR_CYC - 1));
      div_d = (st_q == E_IDLE || tick) ? 16'h0000 : div_q + 16'h0001;
      if (tick) begin
         qtr_d = qtr_q + 2'h1;
      end
      case (st_q)
         E_IDLE: begin
            qtr_d = 2'h0;
            if (start) begin
               st_d = E_START;
               step_d = 7'h00;
               busy_d = 1'b1;
            end
         end
         E_START: if (tick) begin
            case (qtr_q)
               2'h0: sda_lo_d = 1'b0;
               2'h1: scl_lo_d = 1'b0;
               2'h2: sda_lo_d = 1'b1;
               default: begin
                  scl_lo_d = 1'b1;
                  adv = 1'b1;
               end
            endcase
         end
         E_BIT: if (tick) begin
            case (qtr_q)
               2'h0: sda_lo_d = ~tx_q[8];
               2'h1: scl_lo_d = 1'b0;
               2'h2: rx_d = {rx_q[7:0], ee_sda_i};
               default: begin
                  scl_lo_d = 1'b1;
                  tx_d = {tx_q[7:0], 1'b1};
                  bit_d = bit_q + 4'h1;
                  if (bit_q == 4'h8) begin
                     adv = 1'b1;
                     if (step_q >= 7'd5) begin
                        byte_d = {1'b1, 6'(step_q - 7'd5), rx_q[8:1]};
                     end
                  end
               end
            endcase
         end
         E_STOP: if (tick) begin
            case (qtr_q)
               2'h0: sda_lo_d = 1'b1;
               2'h1: scl_lo_d = 1'b0;
               2'h2: sda_lo_d = 1'b0;
               default: begin
                  st_d = E_IDLE;
                  busy_d = 1'b0;
               end
            endcase
         end
         default: st_d = E_IDLE;
      endcase
      if (adv) begin
         step_d = nstep;
         bit_d = 4'h0;
         if (nstep == 7'd3) begin
            st_d = E_START;
         end else if (nstep == STOP_STEP) begin
            st_d = E_STOP;
         end else begin
            st_d = E_BIT;
            // Address byte carries the strap bits
            tx_d = (nstep == 7'd1) ? {dev, 1'b0, 1'b1} :
                   (nstep == 7'd2) ? {`GBDLC_EE_WORD0, 1'b1} :
                   (nstep == 7'd4) ? {dev, 1'b1, 1'b1} :
                   {8'hFF, nstep == STOP_STEP - 7'd1};
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st_q <= E_IDLE;
         div_q <= 16'h0000;
         qtr_q <= 2'h0;
         step_q <= 7'h00;
         tx_q <= 9'h1FF;
         rx_q <= 9'h000;
         bit_q <= 4'h0;
         scl_lo_q <= 1'b0;
         sda_lo_q <= 1'b0;
         busy_q <= 1'b0;
         byte_q <= '0;
      end else begin
         st_q <= st_d;
         div_q <= div_d;
         qtr_q <= qtr_d;
         step_q <= step_d;
         tx_q <= tx_d;
         rx_q <= rx_d;
         bit_q <= bit_d;
         scl_lo_q <= scl_lo_d;
         sda_lo_q <= sda_lo_d;
         busy_q <= busy_d;
         byte_q <= byte_d;
      end
   end
   assign busy = busy_q;
   assign rd_byte = byte_q;
   assign pins = {1'b0, ~scl_lo_q, 1'b0, ~sda_lo_q};

   a_ee_image_span: assert property (@(posedge clk_sys) disable iff (!resetn)
      byte_q.vld |-> byte_q.idx < 6'(IMG))
      else $error("EEPROM byte index beyond image");
endmodule : gbdlc_ee_rd

// File: rtl/gbdlc_top.sv
`timescale 1ns/1ps
`include "gbdlc_map.svh"
// Summary of operation
// - Channel code sets output to supply times code over 1024.
// - Load low: written channel drives its output right after the write.
// - Load high: many writes collect, then all outputs change together.
// - General-call reset with auto-read on reloads registers from EEPROM.
// - General-call reset with auto-read off clears every code to zero.
// - Both EEPROM strap pins low select default EEPROM; image is 48 bytes.
// - Auto-read high at reset release loads registers from EEPROM.
// - Load pin low updates outputs at once; high holds them.
// - Auto-read low at startup skips EEPROM; plain bus slave.
// - Address-select pin picks one of two slave addresses.
module gbdlc_top #(
   parameter int unsigned NCH = `GBDLC_NUM_CHAN,
   parameter int unsigned QTR_CYC = `GBDLC_EE_QTR_CYC
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n,
   input wire logic slave_addr_select,
   input wire logic output_load_hold,
   input wire logic autoread_en,
   input wire logic eeprom_addr_sel0,
   input wire logic eeprom_addr_sel1,
   input wire logic ee_sda_i,
   output gbdlc_pkg::gbdlc_od_s ee_pins,
   output logic [NCH-1:0][`GBDLC_CODE_W-1:0] dac_code,
   output logic ee_loading
);
   import gbdlc_pkg::*;
   localparam int W = `GBDLC_CODE_W;

   // Host read: high byte carries bits 9:8, above read zero
   function automatic logic [7:0] rd_byte(input logic [W-1:0] code,
                                          input logic lsb);
      rd_byte = lsb ? code[7:0] : {6'h00, code[9:8]};
   endfunction : rd_byte

   gbdlc_slv_e st_q, st_d;
   logic scl_q, sda_q, scl_rise, scl_fall, start_c, stop_c;
   logic [7:0] shreg_q, shreg_d, byte_in, cur_rd;
   logic [3:0] bit_q, bit_d;
   logic rw_q, rw_d, gc_q, gc_d, ptrset_q, ptrset_d, ackgo_q, ackgo_d;
   logic drv_q, drv_d, boot_q, ee_go_q, ee_go_d, gc_fire;
   logic [5:0] ptr_q, ptr_d;
   logic [1:0] msb_q, msb_d;
   logic [NCH-1:0][W-1:0] chan_q, chan_d, dac_q, dac_d;
   logic wr_en;
   logic [5:0] wr_idx;
   logic [7:0] wr_data;
   logic ee_busy;
   gbdlc_byte_s ee_byte;
   logic [6:0] my_addr;

   assign scl_rise = scl_i & ~scl_q;
   assign scl_fall = ~scl_i & scl_q;
   assign start_c = scl_i & scl_q & sda_q & ~sda_i;
   assign stop_c = scl_i & scl_q & ~sda_q & sda_i;
   assign byte_in = {shreg_q[6:0], sda_i};
   assign my_addr = {`GBDLC_SLV_BASE, slave_addr_select};
   assign cur_rd = (ptr_q[5:1] < 5'(NCH)) ?
                   rd_byte(chan_q[ptr_q[5:1]], ptr_q[0]) : 8'h00;

   // Bus slave sequencing
   always_comb begin
      st_d = st_q;
      shreg_d = shreg_q;
      bit_d = bit_q;
      rw_d = rw_q;
      gc_d = gc_q;
      ptrset_d = ptrset_q;
      ackgo_d = ackgo_q;
      drv_d = drv_q;
      ptr_d = ptr_q;
      gc_fire = 1'b0;
      wr_en = 1'b0;
      wr_idx = ptr_q;
      wr_data = byte_in;
      if (start_c) begin
         st_d = S_ADDR;
         bit_d = 4'h0;
         drv_d = 1'b0;
         ackgo_d = 1'b0;
      end else if (stop_c) begin
         st_d = S_IDLE;
         drv_d = 1'b0;
         ackgo_d = 1'b0;
      end else begin
         case (st_q)
            S_IDLE: ;
            S_ADDR, S_WDATA: begin
               if (scl_rise) begin
                  shreg_d = byte_in;
                  bit_d = bit_q + 4'h1;
               end
               if (scl_rise && bit_q == 4'h7 && st_q == S_ADDR) begin
                  // No answer while the EEPROM image is loading
                  if (!ee_busy && (byte_in[7:1] == my_addr ||
                      byte_in == {`GBDLC_GC_ADDR, 1'b0})) begin
                     ackgo_d = 1'b1;
                     rw_d = byte_in[0];
                     gc_d = (byte_in[7:1] == `GBDLC_GC_ADDR);
                     ptrset_d = 1'b0;
                  end else begin
                     st_d = S_IDLE;
                  end
               end
               if (scl_rise && bit_q == 4'h7 && st_q == S_WDATA) begin
                  ackgo_d = 1'b1;
                  if (gc_q) begin
                     gc_fire = (byte_in == `GBDLC_GC_RESET);
                  end else if (!ptrset_q) begin
                     ptr_d = byte_in[5:0];
                     ptrset_d = 1'b1;
                  end else begin
                     wr_en = 1'b1;
                     ptr_d = ptr_q + 6'h01;
                  end
               end
               if (scl_fall && ackgo_q) begin
                  st_d = S_ACK;
                  drv_d = 1'b1;
                  ackgo_d = 1'b0;
                  bit_d = 4'h0;
               end
            end
            S_ACK: if (scl_fall) begin
               bit_d = 4'h0;
               if (rw_q) begin
                  st_d = S_RDATA;
                  shreg_d = cur_rd;
                  drv_d = ~cur_rd[7];
                  bit_d = 4'h1;
                  ptr_d = ptr_q + 6'h01;
               end else begin
                  st_d = S_WDATA;
                  drv_d = 1'b0;
               end
            end
            S_RDATA: if (scl_fall) begin
               if (bit_q == 4'h8) begin
                  drv_d = 1'b0;
                  st_d = S_RACK;
               end else begin
                  drv_d = ~shreg_q[6];
                  shreg_d = {shreg_q[6:0], 1'b0};
                  bit_d = bit_q + 4'h1;
               end
            end
            S_RACK: begin
               if (scl_rise) begin
                  ackgo_d = ~sda_i;
                  if (sda_i) begin
                     st_d = S_IDLE;
                  end
               end
               if (scl_fall && ackgo_q) begin
                  ackgo_d = 1'b0;
                  st_d = S_RDATA;
                  shreg_d = cur_rd;
                  drv_d = ~cur_rd[7];
                  bit_d = 4'h1;
                  ptr_d = ptr_q + 6'h01;
               end
            end
            default: st_d = S_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st_q <= S_IDLE;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         shreg_q <= 8'h00;
         bit_q <= 4'h0;
         rw_q <= 1'b0;
         gc_q <= 1'b0;
         ptrset_q <= 1'b0;
         ackgo_q <= 1'b0;
         drv_q <= 1'b0;
         ptr_q <= 6'h00;
      end else begin
         st_q <= st_d;
         scl_q <= scl_i;
         sda_q <= sda_i;
         shreg_q <= shreg_d;
         bit_q <= bit_d;
         rw_q <= rw_d;
         gc_q <= gc_d;
         ptrset_q <= ptrset_d;
         ackgo_q <= ackgo_d;
         drv_q <= drv_d;
         ptr_q <= ptr_d;
      end
   end

   // Channel registers, staging and output latches
   always_comb begin
      chan_d = chan_q;
      msb_d = msb_q;
      ee_go_d = 1'b0;
      if (boot_q && autoread_en) begin
         ee_go_d = 1'b1;
      end
      if (gc_fire && autoread_en) begin
         ee_go_d = 1'b1;
      end else if (gc_fire) begin
         chan_d = '{default: `GBDLC_CODE_RST};
         msb_d = 2'h0;
      end
      // EEPROM image and host share one byte-pair path
      if (ee_byte.vld || wr_en) begin
         if (!(ee_byte.vld ? ee_byte.idx[0] : wr_idx[0])) begin
            msb_d = ee_byte.vld ? ee_byte.data[1:0] : wr_data[1:0];
         end
      end
      // Odd byte completes the 10-bit code
      for (int i = 0; i < NCH; i++) begin
         if (ee_byte.vld && ee_byte.idx[0] && ee_byte.idx[5:1] == 5'(i)) begin
            chan_d[i] = {msb_q, ee_byte.data};
         end else if (wr_en && wr_idx[0] && wr_idx[5:1] == 5'(i)) begin
            chan_d[i] = {msb_q, wr_data};
         end
      end
      // Hold keeps outputs; release moves all codes at once
      dac_d = output_load_hold ? dac_q : chan_q;
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         chan_q <= '{default: `GBDLC_CODE_RST};
         dac_q <= '{default: `GBDLC_CODE_RST};
         msb_q <= 2'h0;
         boot_q <= 1'b1;
         ee_go_q <= 1'b0;
      end else begin
         chan_q <= chan_d;
         dac_q <= dac_d;
         msb_q <= msb_d;
         boot_q <= 1'b0;
         ee_go_q <= ee_go_d;
      end
   end

   gbdlc_ee_rd #(.QTR_CYC(QTR_CYC), .IMG(`GBDLC_IMG_BYTES)) u_ee (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .start(ee_go_q),
      .ea({eeprom_addr_sel1, eeprom_addr_sel0}),
      .ee_sda_i(ee_sda_i),
      .pins(ee_pins),
      .rd_byte(ee_byte),
      .busy(ee_busy)
   );

   // Codes leave as unsigned fractions of the supply over 1024
   assign dac_code = dac_q;
   assign sda_oe_n = ~drv_q;
   assign sda_o = 1'b0;
   assign ee_loading = ee_busy;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   a_dac_follow_imm: assert property (!output_load_hold |=>
      dac_q == $past(chan_q)) else $error("Output missed register");
   a_dac_hold_load: assert property (output_load_hold |=>
      $stable(dac_q)) else $error("Output moved while held");
   a_dac_release: assert property ($fell(output_load_hold) |=>
      dac_q == $past(chan_q)) else $error("Release did not update");
   a_gc_autoread: assert property (gc_fire && autoread_en |=>
      ##1 ee_busy) else $error("General call did not reload");
   a_gc_zero: assert property (gc_fire && !autoread_en |=>
      chan_q == '0) else $error("General call did not clear");
   a_boot_read: assert property (boot_q && autoread_en |=>
      ##1 ee_busy) else $error("Startup load not begun");
   a_boot_skip: assert property (boot_q && !autoread_en |=>
      !ee_busy [*4]) else $error("EEPROM used with auto-read off");
   a_ack_drive: assert property (st_q == S_ACK |->
      !sda_oe_n) else $error("Acknowledge not driven");
   a_code_bits: assert property (st_q == S_RDATA && bit_q == 4'h1 &&
      ptr_q[0] |-> shreg_q[7:2] == 6'h00) else $error("High bits leak");
   c_gc_reset: cover property (gc_fire);
   c_hold_release: cover property (output_load_hold ##1 !output_load_hold);
   c_ee_done: cover property ($fell(ee_busy));
   c_host_read: cover property (st_q == S_RACK);
endmodule : gbdlc_top

// File: bench/gbdlc_ee_model.sv
`timescale 1ns/1ps
module gbdlc_ee_model #(
   parameter logic [6:0] DEV = 7'h50
) (
   input wire logic scl,
   input wire logic sda,
   output logic sda_pull
);
   logic [7:0] mem [0:47];
   logic [7:0] sh;
   logic [5:0] ptr;
   int cnt;
   logic act, hdr, sel, rd, ackme;
   initial begin
      sda_pull = 1'b0;
      act = 1'b0;
      sel = 1'b0;
   end
   always @(negedge sda) begin
      if (scl === 1'b1) begin
         act = 1'b1;
         hdr = 1'b1;
         cnt = 0;
      end
   end
   always @(posedge sda) begin
      if (scl === 1'b1) begin
         act = 1'b0;
         sel = 1'b0;
      end
   end
   always @(posedge scl) begin
      if (act) begin
         if (cnt < 8)
            sh = {sh[6:0], sda};
         cnt = cnt + 1;
         if (cnt == 8) begin
            // Answers only when both strap bits are low
            ackme = hdr ? (sh[7:1] == DEV) : (sel && !rd);
            if (hdr) begin
               sel = ackme;
               rd = sh[0];
            end else if (!rd) begin
               ptr = sh[5:0]; // Image in the first 48 words
            end
         end
         if (cnt == 9) begin
            cnt = 0;
            if (!hdr && rd) begin
               ptr = ptr + 6'h01;
               if (sda)
                  sel = 1'b0;
            end
            hdr = 1'b0;
         end
      end
   end
   // Line left to the pull-up whenever not driven
   always @(negedge scl) begin
      sda_pull = 1'b0;
      if (act && sel && !hdr && rd && cnt < 8)
         sda_pull = !mem[ptr][7 - cnt];
      if (act && cnt == 8 && ackme)
         sda_pull = 1'b1;
   end
endmodule : gbdlc_ee_model

// File: bench/tb_gamma_buffer_dac_load_control.sv
`timescale 1ns/1ps
`include "gbdlc_map.svh"
module tb_gamma_buffer_dac_load_control;
   import gbdlc_pkg::*;
   localparam int NCH = `GBDLC_NUM_CHAN;
   localparam int W = NCH * `GBDLC_CODE_W;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic scl = 1'b1;
   logic sda_h = 1'b1;
   logic a0 = 1'b0;
   logic hold = 1'b0;
   logic aren = 1'b0;
   logic [1:0] easel = 2'b00;
   logic sda_o, sda_oe_n, ee_loading, pull, ack, dirty;
   logic defer = 1'b0;
   logic [9:0] code;
   gbdlc_od_s ee_pins;
   logic [NCH-1:0][`GBDLC_CODE_W-1:0] dac_code, exp_v, prev;
   logic [NCH-1:0][`GBDLC_CODE_W-1:0] q[$];
   int mismatches = 0;
   int tests_run = 0;
   int cycles = 0;
   integer seed = 32'hA33AC4AF;
   wire logic sda_w = sda_h & (sda_oe_n | sda_o);
   wire logic ee_scl = ee_pins.scl_oe_n | ee_pins.scl_o;
   wire logic ee_sda = (ee_pins.sda_oe_n | ee_pins.sda_o) & !pull;
   always #25 clk_sys = ~clk_sys;
   gbdlc_top #(.QTR_CYC(2)) dut (
      .clk_sys(clk_sys), .resetn(resetn), .scl_i(scl), .sda_i(sda_w),
      .sda_o(sda_o), .sda_oe_n(sda_oe_n), .slave_addr_select(a0),
      .output_load_hold(hold), .autoread_en(aren),
      .eeprom_addr_sel0(easel[0]), .eeprom_addr_sel1(easel[1]),
      .ee_sda_i(ee_sda), .ee_pins(ee_pins), .dac_code(dac_code),
      .ee_loading(ee_loading)
   );
   gbdlc_ee_model ee (.scl(ee_scl), .sda(ee_sda), .sda_pull(pull));
   task automatic results;
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : results
   task automatic check(input logic [W-1:0] seen, input logic [W-1:0] want);
      tests_run++;
      if (seen !== want) begin
         mismatches++;
         $display("MISMATCH at %0t: got %h want %h", $time, seen, want);
      end
   endtask : check
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 60000) begin
         mismatches++;
         $display("MISMATCH at %0t: timeout", $time);
         results();
      end
   end
   // Any output change with no note pending is a fault
   always @(posedge clk_sys) begin
      if (resetn && dac_code !== prev) begin
         if (q.size() == 0)
            check(dac_code, prev);
         else
            check(dac_code, q.pop_front());
      end
      prev <= dac_code;
   end
   task automatic note(input int ch, input logic [9:0] c);
      if (exp_v[ch] !== c) begin
         exp_v[ch] = c;
         dirty = 1'b1;
         if (!defer)
            q.push_back(exp_v);
      end
   endtask : note
   task automatic flush;
      if (defer && dirty)
         q.push_back(exp_v);
      defer = 1'b0;
      dirty = 1'b0;
   endtask : flush
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : cyc
   task automatic hbit(input logic b, output logic r);
      cyc(1);
      sda_h <= b;
      cyc(3);
      scl <= 1'b1;
      cyc(2);
      r = sda_w;
      cyc(2);
      scl <= 1'b0;
   endtask : hbit
   task automatic hstart;
      cyc(1);
      sda_h <= 1'b1;
      cyc(3);
      scl <= 1'b1;
      cyc(4);
      sda_h <= 1'b0;
      cyc(4);
      scl <= 1'b0;
   endtask : hstart
   task automatic hstop;
      cyc(1);
      sda_h <= 1'b0;
      cyc(3);
      scl <= 1'b1;
      cyc(4);
      sda_h <= 1'b1;
      cyc(4);
   endtask : hstop
   task automatic hbyte(input logic [7:0] b, output logic a);
      logic r;
      for (int i = 7; i >= 0; i--)
         hbit(b[i], r);
      hbit(1'b1, r);
      a = !r;
   endtask : hbyte
   task automatic hrd(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         hbit(1'b1, d[i]);
      hbit(last, r);
   endtask : hrd
   task automatic wr_ch(input logic [6:0] ad, input int ch,
                        input logic [9:0] c, output logic a);
      logic x;
      hstart();
      hbyte({ad, 1'b0}, a);
      hbyte(8'(2 * ch), x);
      hbyte({6'h00, c[9:8]}, x);
      hbyte(c[7:0], x);
      hstop();
   endtask : wr_ch
   task automatic rd_ch(input int ch);
      logic x;
      logic [7:0] hi, lo;
      hstart();
      hbyte({`GBDLC_SLV_BASE, a0, 1'b0}, x);
      hbyte(8'(2 * ch), x);
      hstart();
      hbyte({`GBDLC_SLV_BASE, a0, 1'b1}, x);
      hrd(1'b0, hi);
      hrd(1'b1, lo);
      hstop();
      check(W'({hi, lo}), W'({6'h00, exp_v[ch]}));
   endtask : rd_ch
   task automatic gcall;
      logic x;
      hstart();
      hbyte({`GBDLC_GC_ADDR, 1'b0}, x);
      hbyte(`GBDLC_GC_RESET, x);
      hstop();
   endtask : gcall
   // Bounded wait, as a stuck load must not hang the run
   task automatic wait_idle;
      int n;
      n = 0;
      cyc(4);
      while (ee_loading === 1'b1 && n < 20000) begin
         cyc(1);
         n++;
      end
      cyc(4);
      check(W'(q.size()), W'(0));
   endtask : wait_idle
   initial begin
      for (int i = 0; i < 48; i++)
         ee.mem[i] = 8'($random(seed));
      exp_v = '0;
      cyc(8);
      resetn <= 1'b1;
      repeat (200) begin
         cyc(1);
         check(W'({ee_loading, ee_scl}), W'(2'b01));
      end
      $display("done: startup without auto-read");
      for (int s = 0; s < 2; s++) begin
         a0 <= s[0];
         cyc(2);
         wr_ch({`GBDLC_SLV_BASE, !s[0]}, 5, 10'h3FF, ack);
         check(W'(ack), W'(0));
         for (int c = 0; c < NCH; c += 23) begin
            code = 10'($random(seed));
            note(c, code);
            wr_ch({`GBDLC_SLV_BASE, s[0]}, c, code, ack);
            check(W'(ack), W'(1));
            cyc(2);
            check(W'(q.size()), W'(0));
            rd_ch(c);
         end
      end
      $display("done: address select and immediate update");
      hold <= 1'b1;
      defer = 1'b1;
      for (int c = 1; c < 4; c++) begin
         code = 10'($random(seed));
         note(c, code);
         wr_ch({`GBDLC_SLV_BASE, a0}, c, code, ack);
      end
      cyc(20);
      flush();
      hold <= 1'b0;
      cyc(4);
      check(W'(q.size()), W'(0));
      $display("done: deferred update");
      defer = 1'b1;
      for (int c = 0; c < NCH; c++)
         note(c, 10'h000);
      flush();
      gcall();
      wait_idle();
      $display("done: general call without auto-read");
      aren <= 1'b1;
      resetn <= 1'b0;
      cyc(8);
      resetn <= 1'b1;
      for (int c = 0; c < NCH; c++)
         note(c, {ee.mem[2 * c][1:0], ee.mem[2 * c + 1]});
      wait_idle();
      $display("done: auto-read at reset");
      code = ~exp_v[3];
      note(3, code);
      wr_ch({`GBDLC_SLV_BASE, a0}, 3, code, ack);
      cyc(4);
      note(3, {ee.mem[6][1:0], ee.mem[7]});
      gcall();
      wait_idle();
      $display("done: general call with auto-read");
      easel <= 2'b01;
      for (int c = 0; c < NCH; c++)
         note(c, 10'h3FF);
      gcall();
      wait_idle();
      $display("done: absent EEPROM reads as released");
      cyc(20);
      results();
   end
endmodule : tb_gamma_buffer_dac_load_control
